// file: inc/xpvt_map.svh
// offsets, field positions, reset values and timing counts of the video timer
`ifndef XPVT_MAP_SVH
`define XPVT_MAP_SVH

`define XPVT_CTRL_OFS      12'h000
`define XPVT_STAT_OFS      12'h004
`define XPVT_CTRL_RST      32'h00000001
`define XPVT_CTRL_EN_BIT   0
`define XPVT_CTRL_PAT_BIT  1
`define XPVT_STAT_MODE_LSB 0
`define XPVT_STAT_EXT_BIT  2
`define XPVT_STAT_BUSY_BIT 3
`define XPVT_STAT_FCNT_LSB 8

`define XPVT_LINK_NS       80
`define XPVT_TVC1_MS       470
`define XPVT_TVC2_MS       230
`define XPVT_TVC4_MS       117
`define XPVT_TVDPW_US      770
`define XPVT_TVD_US        390
`define XPVT_MS_CYC(ms)    (((ms) * 1000000) / `XPVT_LINK_NS)
`define XPVT_US_CYC(us)    (((us) * 1000) / `XPVT_LINK_NS)

`define XPVT_LINES1        16'd2344
`define XPVT_DLINES1       16'd56
`define XPVT_PIX1          16'd2240
`define XPVT_DPIX1         16'd160
`define XPVT_GAP1          16'd526
`define XPVT_LINES2        16'd1172
`define XPVT_DLINES2       16'd28
`define XPVT_PIX2          16'd1120
`define XPVT_DPIX2         16'd80
`define XPVT_GAP2          16'd1726
`define XPVT_LINES4        16'd586
`define XPVT_DLINES4       16'd14
`define XPVT_PIX4          16'd560
`define XPVT_DPIX4         16'd40
`define XPVT_GAP4          16'd2326
`define XPVT_LEAD          16'd21

`endif

// file: inc/xpvt_pkg.sv
// types of the video timer
`default_nettype none
package xpvt_pkg;
	typedef enum logic [2:0] {
		XS_IDLE, XS_DELAY, XS_VSYNC, XS_LEAD, XS_PIX, XS_GAP
	} xpvt_state_t;

	typedef enum logic [1:0] {XM_SINGLE, XM_BIN2, XM_BIN4} xpvt_mode_t;

	typedef struct packed {
		logic        frame_sync;
		logic        line_sync;
		logic        effective;
		logic [11:0] data;
	} xpvt_video_t;

	typedef struct packed {
		logic [15:0] lines;
		logic [15:0] dlines;
		logic [15:0] pix;
		logic [15:0] dpix;
		logic [15:0] gap;
	} xpvt_geom_t;
endpackage
`default_nettype wire

// file: hdl/xpvt_video_timer.sv
// frame, line and pixel timing of the panel video output with apb control
`timescale 1ns/10ps
`default_nettype none
`include "xpvt_map.svh"

module xpvt_video_timer #(
	parameter int TVC1_CYC  = `XPVT_MS_CYC(`XPVT_TVC1_MS),
	parameter int TVC2_CYC  = `XPVT_MS_CYC(`XPVT_TVC2_MS),
	parameter int TVC4_CYC  = `XPVT_MS_CYC(`XPVT_TVC4_MS),
	parameter int TVDPW_CYC = `XPVT_US_CYC(`XPVT_TVDPW_US),
	parameter int TVD_CYC   = `XPVT_US_CYC(`XPVT_TVD_US)
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        link_clk,
	input  wire logic        pixel_merge_select_lo,
	input  wire logic        pixel_merge_select_hi,
	input  wire logic        trigger_source_select,
	input  wire logic        grabber_trigger_input,
	input  wire logic        coax_trigger_input,
	input  wire logic [11:0] sensor_sample,
	output logic             frame_sync,
	output logic             line_sync,
	output logic             pixel_clock_out,
	output logic             pixel_effective,
	output logic [11:0]      pixel_data
);
	if (TVC1_CYC >= 2**24 || TVC2_CYC >= 2**24 || TVC4_CYC >= 2**24 ||
			TVD_CYC >= 2**24 || TVDPW_CYC >= 2**24 || TVD_CYC < 1 ||
			TVDPW_CYC < 1 || TVC4_CYC < 1) begin : g_chk
		$error("timing count out of range");
	end
	function automatic xpvt_pkg::xpvt_geom_t geom(xpvt_pkg::xpvt_mode_t m);
		xpvt_pkg::xpvt_geom_t g;
		g = '{`XPVT_LINES1, `XPVT_DLINES1, `XPVT_PIX1, `XPVT_DPIX1,
			`XPVT_GAP1};
		if (m == xpvt_pkg::XM_BIN2)
			g = '{`XPVT_LINES2, `XPVT_DLINES2, `XPVT_PIX2, `XPVT_DPIX2,
				`XPVT_GAP2};
		if (m == xpvt_pkg::XM_BIN4)
			g = '{`XPVT_LINES4, `XPVT_DLINES4, `XPVT_PIX4, `XPVT_DPIX4,
				`XPVT_GAP4};
		return g;
	endfunction
	// apb slave, one wait state
	logic [31:0] ctrl_r, ctrl_nxt, prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic [11:0] stat_f;
	logic [7:0]  fcnt_bin;
	always_comb begin
		fcnt_bin[7] = stat_f[11];
		for (int i = 6; i >= 0; i--) begin
			fcnt_bin[i] = stat_f[4 + i] ^ fcnt_bin[i + 1];
		end
	end
	always_comb begin
		ctrl_nxt = ctrl_r;
		prdata_nxt = 32'h00000000;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		if (psel && penable && !pready_r) begin
			pready_nxt = 1'b1;
			if (paddr == `XPVT_CTRL_OFS) begin
				if (pwrite)
					ctrl_nxt = {30'h0, pwdata[1:0]};
				else
					prdata_nxt = ctrl_r;
			end else if (paddr == `XPVT_STAT_OFS) begin
				if (!pwrite) begin
					prdata_nxt[`XPVT_STAT_MODE_LSB +: 2] = stat_f[1:0];
					prdata_nxt[`XPVT_STAT_EXT_BIT] = stat_f[2];
					prdata_nxt[`XPVT_STAT_BUSY_BIT] = stat_f[3];
					prdata_nxt[`XPVT_STAT_FCNT_LSB +: 8] = fcnt_bin;
				end
			end else begin
				pslverr_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `XPVT_CTRL_RST;
			prdata_r <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end
	assign pready = pready_r;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	// link-domain reset: asserted at once, released on link_clk
	logic [1:0] lrst_r;
	logic       lrst_n;
	always_ff @(posedge link_clk or negedge presetn) begin
		if (!presetn)
			lrst_r <= 2'b00;
		else
			lrst_r <= {lrst_r[0], 1'b1};
	end
	assign lrst_n = lrst_r[1];
	// pins and control bits into link domain, status back to pclk
	logic [6:0]  in_raw, in_f;
	logic [11:0] stat_raw;
	localparam logic [6:0] IN_IDLE = 7'b0011000; // trigger pins rest high
	assign in_raw = {ctrl_r[`XPVT_CTRL_PAT_BIT], ctrl_r[`XPVT_CTRL_EN_BIT],
		coax_trigger_input, grabber_trigger_input, trigger_source_select,
		pixel_merge_select_hi, pixel_merge_select_lo};
	for (genvar i = 0; i < 7; i++) begin : g_in
		logic [2:0] s_r;
		logic       f_r;
		always_ff @(posedge link_clk or negedge lrst_n) begin
			if (!lrst_n) begin
				s_r <= {3{IN_IDLE[i]}};
				f_r <= IN_IDLE[i];
			end else begin
				s_r <= {s_r[1:0], in_raw[i]};
				f_r <= (s_r[1] == s_r[2]) ? s_r[2] : f_r;
			end
		end
		assign in_f[i] = f_r;
	end
	for (genvar i = 0; i < 12; i++) begin : g_st
		logic [2:0] s_r;
		logic       f_r;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				s_r <= 3'b000;
				f_r <= 1'b0;
			end else begin
				s_r <= {s_r[1:0], stat_raw[i]};
				f_r <= (s_r[1] == s_r[2]) ? s_r[2] : f_r;
			end
		end
		assign stat_f[i] = f_r;
	end
	// video timing on the link clock
	xpvt_pkg::xpvt_state_t st_r, st_nxt;
	xpvt_pkg::xpvt_mode_t  mode_r, mode_nxt, mode_pin;
	xpvt_pkg::xpvt_video_t vid_r, vid_nxt;
	xpvt_pkg::xpvt_geom_t  g;
	logic [23:0] cnt_r, cnt_nxt, per_r, per_nxt, tvc;
	logic [15:0] line_r, line_nxt;
	logic [7:0]  fcnt_r, fcnt_nxt, fgray_r, fgray_nxt;
	logic        ext_r, ext_nxt, pck_r, pck_nxt, trg_r, trg_nxt, trg;
	logic        start;

	always_comb begin
		mode_pin = xpvt_pkg::XM_SINGLE;
		if (in_f[0] && in_f[1])
			mode_pin = xpvt_pkg::XM_BIN4;
		else if (in_f[0])
			mode_pin = xpvt_pkg::XM_BIN2;
		g = geom(mode_r);
		case (mode_r)
			xpvt_pkg::XM_BIN2: tvc = 24'(TVC2_CYC);
			xpvt_pkg::XM_BIN4: tvc = 24'(TVC4_CYC);
			default:           tvc = 24'(TVC1_CYC);
		endcase
	end
	assign trg = in_f[3] & in_f[4];
	always_comb begin
		st_nxt = st_r;
		mode_nxt = mode_r;
		ext_nxt = ext_r;
		cnt_nxt = cnt_r + 24'd1;
		line_nxt = line_r;
		fcnt_nxt = fcnt_r;
		pck_nxt = ~pck_r;
		trg_nxt = trg;
		per_nxt = (per_r == 24'hffffff) ? per_r : per_r + 24'd1;
		start = 1'b0;
		if (in_f[2])
			start = trg && !trg_r;
		else
			start = per_r >= tvc - 24'd1;
		case (st_r)
			xpvt_pkg::XS_IDLE: begin
				cnt_nxt = 24'd0;
				if (start && in_f[5]) begin
					mode_nxt = mode_pin;
					ext_nxt = in_f[2];
					per_nxt = 24'd0;
					fcnt_nxt = fcnt_r + 8'd1;
					st_nxt = in_f[2] ? xpvt_pkg::XS_DELAY : xpvt_pkg::XS_VSYNC;
				end
			end
			xpvt_pkg::XS_DELAY: begin
				if (cnt_r == 24'(TVD_CYC - 1)) begin
					cnt_nxt = 24'd0;
					st_nxt = xpvt_pkg::XS_VSYNC;
				end
			end
			xpvt_pkg::XS_VSYNC: begin
				if (cnt_r == 24'(TVDPW_CYC - 1)) begin
					cnt_nxt = 24'd0;
					line_nxt = 16'd0;
					st_nxt = xpvt_pkg::XS_LEAD;
				end
			end
			default: begin
				// pixel steps happen as the output clock falls
				cnt_nxt = cnt_r;
				if (pck_r) begin
					cnt_nxt = cnt_r + 24'd1;
					if (st_r == xpvt_pkg::XS_LEAD &&
							cnt_r[15:0] == `XPVT_LEAD - 16'd1) begin
						cnt_nxt = 24'd0;
						st_nxt = xpvt_pkg::XS_PIX;
					end else if (st_r == xpvt_pkg::XS_PIX &&
							cnt_r[15:0] == g.pix + g.dpix - 16'd1) begin
						cnt_nxt = 24'd0;
						st_nxt = xpvt_pkg::XS_GAP;
					end else if (st_r == xpvt_pkg::XS_GAP &&
							cnt_r[15:0] == g.gap - 16'd1) begin
						cnt_nxt = 24'd0;
						line_nxt = line_r + 16'd1;
						st_nxt = xpvt_pkg::XS_PIX;
						if (line_r == g.lines + g.dlines - 16'd1)
							st_nxt = xpvt_pkg::XS_IDLE;
					end
				end
			end
		endcase
		fgray_nxt = fcnt_nxt ^ (fcnt_nxt >> 1);
		vid_nxt.frame_sync = st_nxt != xpvt_pkg::XS_VSYNC;
		vid_nxt.line_sync = st_nxt == xpvt_pkg::XS_PIX;
		vid_nxt.effective = vid_nxt.line_sync && cnt_nxt[15:0] < g.pix &&
			line_nxt < g.lines;
		vid_nxt.data = 12'h000;
		if (vid_nxt.line_sync)
			vid_nxt.data = in_f[6] ? cnt_nxt[11:0] + line_nxt[11:0] :
				sensor_sample;
		if (!pck_r) begin
			vid_nxt = vid_r;
			if (st_r != xpvt_pkg::XS_LEAD && st_r != xpvt_pkg::XS_PIX &&
					st_r != xpvt_pkg::XS_GAP)
				vid_nxt.frame_sync = st_nxt != xpvt_pkg::XS_VSYNC;
		end
	end

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			st_r <= xpvt_pkg::XS_IDLE;
			mode_r <= xpvt_pkg::XM_SINGLE;
			vid_r <= '{1'b1, 1'b0, 1'b0, 12'h000};
			cnt_r <= 24'd0;
			per_r <= 24'd0;
			line_r <= 16'd0;
			fcnt_r <= 8'h00;
			fgray_r <= 8'h00;
			ext_r <= 1'b0;
			pck_r <= 1'b0;
			trg_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
			mode_r <= mode_nxt;
			vid_r <= vid_nxt;
			cnt_r <= cnt_nxt;
			per_r <= per_nxt;
			line_r <= line_nxt;
			fcnt_r <= fcnt_nxt;
			fgray_r <= fgray_nxt;
			ext_r <= ext_nxt;
			pck_r <= pck_nxt;
			trg_r <= trg_nxt;
		end
	end
	assign stat_raw = {fgray_r, st_r != xpvt_pkg::XS_IDLE, ext_r, mode_r};
	assign frame_sync = vid_r.frame_sync;
	assign line_sync = vid_r.line_sync;
	assign pixel_effective = vid_r.effective;
	assign pixel_data = vid_r.data;
	assign pixel_clock_out = pck_r;
	// checking helpers
	logic [23:0] lo_cnt_r, dly_cnt_r;
	logic [15:0] hi_cnt_r, ls_cnt_r;

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			lo_cnt_r <= 24'd0;
			dly_cnt_r <= 24'd0;
			hi_cnt_r <= 16'd0;
			ls_cnt_r <= 16'd0;
		end else begin
			lo_cnt_r <= vid_r.frame_sync ? 24'd0 : lo_cnt_r + 24'd1;
			dly_cnt_r <= (st_r == xpvt_pkg::XS_DELAY) ? dly_cnt_r + 24'd1 :
				24'd0;
			hi_cnt_r <= vid_r.line_sync ? hi_cnt_r + 16'd1 : 16'd0;
			if (!vid_r.frame_sync)
				ls_cnt_r <= 16'd0;
			else if (vid_nxt.line_sync && !vid_r.line_sync)
				ls_cnt_r <= ls_cnt_r + 16'd1;
		end
	end
	sequence s_delay_end;
		$past(st_r) == xpvt_pkg::XS_DELAY && st_r == xpvt_pkg::XS_VSYNC;
	endsequence
	sequence s_frame_start;
		st_r == xpvt_pkg::XS_IDLE && st_nxt != xpvt_pkg::XS_IDLE;
	endsequence
	a_vsync_width: assert property (@(posedge link_clk) disable iff (!lrst_n)
		$rose(vid_r.frame_sync) |-> lo_cnt_r == 24'(TVDPW_CYC))
		else $error("frame sync low width wrong");
	a_line_pixels: assert property (@(posedge link_clk) disable iff (!lrst_n)
		$fell(vid_r.line_sync) |->
		hi_cnt_r == 16'((g.pix + g.dpix) * 2))
		else $error("line sync width wrong");
	a_lines_frame: assert property (@(posedge link_clk) disable iff (!lrst_n)
		st_r == xpvt_pkg::XS_GAP && st_nxt == xpvt_pkg::XS_IDLE |->
		ls_cnt_r == g.lines + g.dlines)
		else $error("line count per frame wrong");
	a_mode_decode: assert property (@(posedge link_clk) disable iff (!lrst_n)
		s_frame_start |=> mode_r == $past(mode_pin))
		else $error("merge mode not decoded");
	a_mode_held: assert property (@(posedge link_clk) disable iff (!lrst_n)
		st_r != xpvt_pkg::XS_IDLE |=> $stable(mode_r))
		else $error("mode changed inside frame");
	a_int_ignore: assert property (@(posedge link_clk) disable iff (!lrst_n)
		s_frame_start and !in_f[2] |=> st_r == xpvt_pkg::XS_VSYNC)
		else $error("internal mode used trigger delay");
	a_ext_delay: assert property (@(posedge link_clk) disable iff (!lrst_n)
		s_delay_end |-> $past(dly_cnt_r) == 24'(TVD_CYC - 1))
		else $error("trigger delay wrong");
	a_eff_marked: assert property (@(posedge link_clk) disable iff (!lrst_n)
		vid_r.effective |-> vid_r.line_sync && vid_r.frame_sync)
		else $error("effective flag outside line");
	a_data_stable: assert property (@(posedge link_clk) disable iff (!lrst_n)
		$changed({vid_r.line_sync, vid_r.effective, vid_r.data}) |->
		!pck_r)
		else $error("video changed while pixel clock high");
	a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready_r |=> pready_r ##1 !pready_r)
		else $error("apb answer not one wait state");
endmodule
`default_nettype wire

// file: verification/xpvt_grabber_model.sv
// frame grabber model: drives mode and trigger pins, measures the video
`timescale 1ns/10ps
`default_nettype none
module xpvt_grabber_model (
	input  wire logic        link_clk,
	input  wire logic        rst_n,
	input  wire logic [1:0]  merge_req,
	input  wire logic        ext_req,
	input  wire logic        use_coax,
	input  wire logic        fire,
	input  wire logic [3:0]  pulse_w,
	input  wire logic        pat_on,
	input  wire logic        frame_sync,
	input  wire logic        line_sync,
	input  wire logic        pixel_clock_out,
	input  wire logic        pixel_effective,
	input  wire logic [11:0] pixel_data,
	output logic             pixel_merge_select_lo,
	output logic             pixel_merge_select_hi,
	output logic             trigger_source_select,
	output logic             grabber_trigger_input,
	output logic             coax_trigger_input,
	output logic             rep_stb,
	output logic [1:0]       rep_kind,
	output logic [15:0]      rep_a,
	output logic [15:0]      rep_b,
	output logic [15:0]      rep_c
);
	logic        fire_q = 1'b0;
	logic        fs_q;
	logic        ls_q;
	logic        dly_on;
	logic [3:0]  pw = 4'h0;
	logic [15:0] fs_n, dly_n, pix_n, eff_n, err_n, gap_n, line_n;
	assign pixel_merge_select_lo = merge_req[0];
	assign pixel_merge_select_hi = merge_req[1];
	assign trigger_source_select = ext_req;
	// low pulse on the chosen input, the other one held high
	assign grabber_trigger_input = !(pw != 4'h0 && !use_coax);
	assign coax_trigger_input    = !(pw != 4'h0 && use_coax);
	task automatic rep(input logic [1:0] k, input logic [15:0] a, b, c);
		rep_stb  <= 1'b1;
		rep_kind <= k;
		rep_a    <= a;
		rep_b    <= b;
		rep_c    <= c;
	endtask
	always @(posedge link_clk) begin
		rep_stb <= 1'b0;
		fire_q  <= fire;
		if (fire && !fire_q)
			pw <= pulse_w;
		else if (pw != 4'h0)
			pw <= pw - 4'h1;
		if (!rst_n) begin
			{fs_n, pix_n, eff_n, err_n, gap_n, line_n} = '0;
			fs_q   = 1'b1;
			ls_q   = 1'b0;
			dly_on = 1'b0;
		end else begin
			if (dly_on && !frame_sync) begin
				rep(2'd1, dly_n, 16'h0, 16'h0);
				dly_on = 1'b0;
			end
			dly_n = dly_n + 16'h1;
			if (pw == 4'h1) begin
				dly_on = 1'b1;
				dly_n  = 16'h0;
			end
			if (!frame_sync)
				fs_n = fs_n + 16'h1;
			else begin
				if (!fs_q)
					rep(2'd0, fs_n, 16'h0, 16'h0);
				fs_n = 16'h0;
			end
			fs_q = frame_sync;
			// sample while the pixel clock is high, as a grabber does
			if (pixel_clock_out) begin
				if (line_sync) begin
					if (!ls_q && line_n != 16'h0)
						rep(2'd3, gap_n, 16'h0, 16'h0);
					if (pat_on && pixel_effective &&
							pixel_data !== pix_n[11:0] + line_n[11:0])
						err_n = err_n + 16'h1;
					pix_n = pix_n + 16'h1;
					eff_n = eff_n + {15'h0, pixel_effective};
				end else begin
					if (ls_q) begin
						rep(2'd2, pix_n, eff_n, err_n);
						{pix_n, eff_n, err_n, gap_n} = '0;
						line_n = line_n + 16'h1;
					end
					gap_n = gap_n + 16'h1;
					if (pixel_data !== 12'h000)
						err_n = err_n + 16'h1;
				end
				ls_q = line_sync;
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/test_xpvt_video_timer.sv
// testbench of the panel video timer
`timescale 1ns/10ps
`default_nettype none
`include "xpvt_map.svh"
module test_xpvt_video_timer;
	typedef struct packed {logic [1:0] k; logic [15:0] a, b, c;} xpvt_vnote_t;
	typedef struct packed {logic [31:0] m, d; logic e;} xpvt_anote_t;
	logic        pclk = 0, link_clk = 0, presetn = 0;
	logic [11:0] paddr = 0, sensor_sample = 0, pdata;
	logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [31:0] pwdata = 0, prdata;
	logic [1:0]  merge_req = 0, rep_kind;
	logic        ext_req = 0, use_coax = 0, fire = 0, pat_on = 0;
	logic [3:0]  pulse_w = 4'h1;
	logic        lo, hi, tsel, gtrig, ctrig, fs, ls, pco, peff, rep_stb;
	logic [15:0] rep_a, rep_b, rep_c;
	int          err_count = 0, n_checks = 0;
	xpvt_anote_t aq[$], an;
	xpvt_vnote_t vq[$], vn;
	initial forever #5 pclk = ~pclk;
	initial begin
		#3;
		forever #40 link_clk = ~link_clk;
	end
	xpvt_video_timer #(.TVC1_CYC(200), .TVC2_CYC(200), .TVC4_CYC(200),
			.TVDPW_CYC(20), .TVD_CYC(10)) xpvt_video_timer_i (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .link_clk(link_clk),
		.pixel_merge_select_lo(lo), .pixel_merge_select_hi(hi),
		.trigger_source_select(tsel), .grabber_trigger_input(gtrig),
		.coax_trigger_input(ctrig), .sensor_sample(sensor_sample),
		.frame_sync(fs), .line_sync(ls), .pixel_clock_out(pco),
		.pixel_effective(peff), .pixel_data(pdata));
	xpvt_grabber_model xpvt_grabber_model_i (
		.link_clk(link_clk), .rst_n(presetn), .merge_req(merge_req),
		.ext_req(ext_req), .use_coax(use_coax), .fire(fire),
		.pulse_w(pulse_w), .pat_on(pat_on), .frame_sync(fs), .line_sync(ls),
		.pixel_clock_out(pco), .pixel_effective(peff), .pixel_data(pdata),
		.pixel_merge_select_lo(lo), .pixel_merge_select_hi(hi),
		.trigger_source_select(tsel), .grabber_trigger_input(gtrig),
		.coax_trigger_input(ctrig), .rep_stb(rep_stb), .rep_kind(rep_kind),
		.rep_a(rep_a), .rep_b(rep_b), .rep_c(rep_c));
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("mismatches %0d checks %0d", err_count, n_checks);
		if (err_count == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic apb(input logic [11:0] a, input logic w,
			input logic [31:0] d, m, x, input logic e);
		int n;
		n = 0;
		aq.push_back({m, x, e});
		@(posedge pclk);
		psel   <= 1;
		paddr  <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			check(0, 1);
		psel    <= 0;
		penable <= 0;
	endtask
	task automatic do_reset(input logic [1:0] m, input logic x, c);
		@(posedge pclk);
		presetn   <= 0;
		merge_req <= m;
		ext_req   <= x;
		use_coax  <= c;
		pat_on    <= 0;
		repeat (8) @(posedge link_clk);
		@(posedge pclk);
		presetn <= 1;
		repeat (8) @(posedge link_clk);
	endtask
	task automatic wait_q(input int s, input int lim);
		int n;
		n = 0;
		while (vq.size() > s && n < lim) begin
			@(posedge link_clk);
			n++;
		end
		if (vq.size() > s)
			check(0, 1);
	endtask
	task automatic fire_pulse;
		@(posedge link_clk);
		pulse_w <= 4'($urandom_range(2, 9));
		fire    <= 1;
		@(posedge link_clk);
		fire <= 0;
	endtask
	always @(posedge link_clk)
		sensor_sample <= 12'($urandom);
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1) begin
			an = aq.pop_front();
			check(prdata & an.m, an.d);
			check(pslverr, an.e);
		end
	always @(posedge link_clk)
		if (rep_stb === 1'b1) begin
			vn = vq.pop_front();
			if (vn.k == 2'd1)
				check(rep_kind == 2'd1 && rep_a >= vn.a && rep_a <= vn.b, 1);
			else
				check({rep_kind, rep_a, rep_b, rep_c}, vn);
		end
	initial begin
		void'($urandom(92844));
		do_reset(2'b00, 0, 1);
		apb(`XPVT_CTRL_OFS, 0, 0, '1, `XPVT_CTRL_RST, 0);
		apb(`XPVT_STAT_OFS, 0, 0, 32'h0000000f, 0, 0);
		apb({10'($urandom_range(2, 1023)), 2'b00}, 0, 0, '1, 0, 1);
		apb(`XPVT_STAT_OFS, 1, $urandom, 0, 0, 0);
		apb(`XPVT_CTRL_OFS, 1, 0, 0, 0, 0);
		repeat (300) @(posedge link_clk);
		check(fs, 1);
		pat_on <= 1;
		vq = '{{2'd0, 16'd20, 32'd0}, {2'd2, 16'd2400, 16'd2240, 16'd0},
			{2'd3, 16'd526, 32'd0}};
		apb(`XPVT_CTRL_OFS, 1, 3, 0, 0, 0);
		wait_q(2, 2000);
		merge_req <= 2'b11;
		apb(`XPVT_STAT_OFS, 0, 0, 32'h0000000f, 32'h8, 0);
		wait_q(0, 9000);
		do_reset(2'b11, 1, 1);
		repeat (300) @(posedge link_clk);
		check(fs, 1);
		vq = '{{2'd1, 16'd10, 16'd18, 16'd0}, {2'd0, 16'd20, 32'd0},
			{2'd2, 16'd600, 16'd560, 16'd0}};
		fire_pulse;
		wait_q(1, 500);
		apb(`XPVT_STAT_OFS, 0, 0, 32'h0000000f, 32'he, 0);
		wait_q(0, 3000);
		do_reset(2'b01, 1, 0);
		vq = '{{2'd1, 16'd10, 16'd18, 16'd0}, {2'd0, 16'd20, 32'd0},
			{2'd2, 16'd1200, 16'd1120, 16'd0}};
		fire_pulse;
		wait_q(1, 500);
		apb(`XPVT_STAT_OFS, 0, 0, 32'h0000000f, 32'hd, 0);
		wait_q(0, 4000);
		final_report;
	end
	initial begin
		#950000;
		check(0, 1);
		final_report;
	end
endmodule
`default_nettype wire
